// ===== rtl/canraf_pkg.sv
// package: register map, field layout and reset values for the can reset/filter/timing block
package canraf_pkg;
  // register indices (byte address = 4 * index)
  localparam logic [3:0] IDX_CONTROL = 4'h0;
  localparam logic [3:0] IDX_COMMAND = 4'h1;
  localparam logic [3:0] IDX_STATUS = 4'h2;
  localparam logic [3:0] IDX_IRQ_FLAG = 4'h3;
  localparam logic [3:0] IDX_ACCEPT_CODE = 4'h4;
  localparam logic [3:0] IDX_ACCEPT_MASK = 4'h5;
  localparam logic [3:0] IDX_BIT_TIMING_ZERO = 4'h6;
  localparam logic [3:0] IDX_RX_DATA = 4'h7;
  // control register fields
  localparam int CTL_RESET_REQ = 0;
  localparam int CTL_RX_IRQ_EN = 1;
  localparam int CTL_TX_IRQ_EN = 2;
  localparam int CTL_OVR_IRQ_EN = 4;
  localparam int CTL_REF_ACTIVE = 5;
  localparam int CTL_TEST_MODE = 7;
  // command register fields
  localparam int CMD_TX_REQ = 0;
  localparam int CMD_ABORT_TX = 1;
  localparam int CMD_RELEASE_RX = 2;
  localparam int CMD_CLEAR_OVR = 3;
  localparam int CMD_SLEEP = 4;
  localparam int CMD_RX1_ACTIVE = 6;
  localparam int CMD_RX0_ACTIVE = 7;
  // status register fields
  localparam int ST_RX_FULL = 0;
  localparam int ST_OVERRUN = 1;
  localparam int ST_TX_FREE = 2;
  localparam int ST_TX_DONE = 3;
  localparam int ST_RX_ACTIVE = 4;
  localparam int ST_TX_ACTIVE = 5;
  localparam int ST_ERROR = 6;
  localparam int ST_BUS_OFF = 7;
  // interrupt flag fields
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_OVR = 3;
  // field positions in bit timing zero
  localparam int BT_PRESCALE_MSB = 5;
  localparam int BT_JUMP_LSB = 6;
  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h21;
  localparam logic [7:0] STATUS_RST = 8'h0c;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  // count widths and id field
  localparam int PRESCALE_W = 7;
  localparam int ID_HI_MSB = 10;
  localparam int ID_HI_LSB = 3;
endpackage

// ===== rtl/canraf_fifo.sv
// file: synchronous valid/ready fifo used as the receive buffer store
`timescale 1ns/1ps
`default_nettype none
module canraf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  // fill side
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // drain side
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // storage words
  logic [AW-1:0] wr_ptr;  // next write slot
  logic [AW-1:0] rd_ptr;  // next read slot
  logic [AW:0] count;  // words held
  logic do_wr;
  logic do_rd;

  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign level_o = count;
  assign do_wr = in_valid_i && in_ready_o;
  assign do_rd = out_valid_o && out_ready_i;

  // storage write, no reset needed on the array
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers and count; flush empties the store in one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule
`default_nettype wire

// ===== rtl/canraf_top.sv
// file: can controller reset state, acceptance filter, receive store and prescaler
// Behaviour
// - reset request forces idle, fixed command pattern, cleared flags
// - external reset also forces bus and reference bits
// - filter and timing registers writable only during reset
// - accepted message stored into empty buffer sequentially
// - accepted message without free buffer sets overrun
// - complete reception sets full, enabled receive flag
// - own accepted transmission stored too, overrun if full
// - accept when masked id bits equal code
// - mask high is don't care, low relevant
// - resynchronize on every relevant bus edge
// - resync step limited to jump width plus one
// - tick period two clocks times prescale plus one
// - code, mask, timing at indices four five six
// - bus off sets reset request until cpu clears
// - reading flags clears them; any flag raises irq
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module canraf_top
  import canraf_pkg::*;
#(
  parameter int MSG_BYTES = 10,  // descriptor plus data bytes per buffer
  parameter int FIFO_DEPTH = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // protocol engine side: message bytes and events
  input wire logic [10:0] msg_id_i,
  input wire logic msg_start_i,
  input wire logic msg_own_tx_i,
  input wire logic [7:0] msg_byte_i,
  input wire logic msg_byte_valid_i,
  input wire logic msg_done_i,
  input wire logic tx_done_i,
  input wire logic bus_off_i,
  input wire logic bus_edge_i,
  input wire logic [3:0] phase_err_i,
  // timing and status outputs
  output logic scl_tick_o,
  output logic [2:0] resync_step_o,
  output logic resync_o,
  output logic reset_request_o,
  output logic irq_o
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // registers
  logic [7:0] control_reg;  // reset request, enables, reference
  logic [7:0] command_reg;  // latched command bits
  logic [7:0] status_reg;  // device state
  logic [7:0] irq_flag_reg;  // sticky interrupt flags
  logic [7:0] accept_code;
  logic [7:0] accept_mask;
  logic [7:0] bit_timing_zero;
  logic ext_reset_seen;  // first reset request came from rst_i

  // bus decode
  logic [3:0] idx;
  logic req;
  logic wr_lo;
  logic rd_now;
  logic cfg_idx;
  logic mapped;
  assign idx = adr_i[5:2];
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign wr_lo = req && we_i && sel_i[0];
  assign rd_now = req && !we_i;
  assign cfg_idx = (idx == IDX_ACCEPT_CODE) || (idx == IDX_ACCEPT_MASK) || (idx == IDX_BIT_TIMING_ZERO);
  assign mapped = (idx <= IDX_RX_DATA) && adr_i[1:0] == 2'b00;

  // acceptance test: bitwise equality or mask must be all ones
  logic [7:0] id_hi;
  logic accept;
  assign id_hi = msg_id_i[ID_HI_MSB:ID_HI_LSB];
  assign accept = ((~(id_hi ^ accept_code)) | accept_mask) == BYTE_ONES;

  // receive store, three message buffers deep in bytes of a fifo
  logic fifo_in_ready;
  logic [7:0] fifo_out;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [LW-1:0] fifo_level;
  logic buf_free;
  logic storing;  // current message being written
  logic store_own;  // current message is our own transmission
  logic push;
  logic rst_req;
  assign rst_req = control_reg[CTL_RESET_REQ];
  assign buf_free = (fifo_level + LW'(MSG_BYTES)) <= LW'(FIFO_DEPTH) && fifo_in_ready;
  assign push = storing && msg_byte_valid_i;
  assign fifo_pop = rd_now && idx == IDX_RX_DATA && fifo_out_valid;

  canraf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_store (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(rst_req),
    .in_data_i(msg_byte_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .level_o(fifo_level)
  );

  // message storage control
  logic ovr_event;
  assign ovr_event = msg_start_i && accept && !buf_free && !rst_req;
  always_ff @(posedge clk_i) begin
    if (rst_i || rst_req) begin
      storing <= 1'b0;
      store_own <= 1'b0;
    end else if (msg_start_i) begin
      // own frames also stored: arbitration loss is unknown at start
      storing <= accept && buf_free;
      store_own <= msg_own_tx_i;
    end else if (msg_done_i) begin
      storing <= 1'b0;
    end
  end

  logic rx_complete;
  assign rx_complete = msg_done_i && storing && !store_own;

  // control register; bus off forces reset request, cpu clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_reg <= CONTROL_RST;
    end else begin
      if (wr_lo && idx == IDX_CONTROL) begin
        control_reg <= dat_i[7:0];
      end
      if (bus_off_i) begin
        control_reg[CTL_RESET_REQ] <= 1'b1;
      end
      if (rst_req || (wr_lo && idx == IDX_CONTROL && dat_i[CTL_RESET_REQ])) begin
        control_reg[CTL_TEST_MODE] <= 1'b0;
      end
    end
  end

  // strap-like flag: note whether reset request stems from rst_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_reset_seen <= 1'b1;
    end else if (!rst_req) begin
      ext_reset_seen <= 1'b0;
    end
  end

  // command register; reset request forces the documented pattern
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      command_reg <= BYTE_ZERO;
      command_reg[CMD_RX0_ACTIVE] <= 1'b1;
      command_reg[CMD_RX1_ACTIVE] <= 1'b1;
      command_reg[CMD_CLEAR_OVR] <= 1'b1;
      command_reg[CMD_RELEASE_RX] <= 1'b1;
    end else if (rst_req) begin
      command_reg[CMD_SLEEP] <= 1'b0;
      command_reg[CMD_ABORT_TX] <= 1'b0;
      command_reg[CMD_TX_REQ] <= 1'b0;
      command_reg[CMD_CLEAR_OVR] <= 1'b1;
      command_reg[CMD_RELEASE_RX] <= 1'b1;
      if (ext_reset_seen) begin
        command_reg[CMD_RX0_ACTIVE] <= 1'b1;
        command_reg[CMD_RX1_ACTIVE] <= 1'b1;
      end
    end else if (wr_lo && idx == IDX_COMMAND) begin
      command_reg <= dat_i[7:0];
    end else begin
      // one-shot commands clear themselves after one cycle
      command_reg[CMD_CLEAR_OVR] <= 1'b0;
      command_reg[CMD_RELEASE_RX] <= 1'b0;
      command_reg[CMD_ABORT_TX] <= 1'b0;
      if (tx_done_i) begin
        command_reg[CMD_TX_REQ] <= 1'b0;
      end
    end
  end

  // status register; events win over clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_reg <= STATUS_RST;
    end else if (rst_req) begin
      status_reg[ST_TX_ACTIVE] <= 1'b0;
      status_reg[ST_RX_ACTIVE] <= 1'b0;
      status_reg[ST_TX_DONE] <= 1'b1;
      status_reg[ST_TX_FREE] <= 1'b1;
      status_reg[ST_OVERRUN] <= 1'b0;
      status_reg[ST_RX_FULL] <= 1'b0;
      status_reg[ST_BUS_OFF] <= ext_reset_seen ? 1'b0 : bus_off_i;
      if (ext_reset_seen) begin
        status_reg[ST_ERROR] <= 1'b0;
      end
    end else begin
      status_reg[ST_BUS_OFF] <= bus_off_i;
      status_reg[ST_RX_ACTIVE] <= storing && !store_own;
      status_reg[ST_TX_ACTIVE] <= command_reg[CMD_TX_REQ];
      if (command_reg[CMD_TX_REQ]) begin
        status_reg[ST_TX_DONE] <= 1'b0;
        status_reg[ST_TX_FREE] <= 1'b0;
      end
      if (tx_done_i) begin
        status_reg[ST_TX_DONE] <= 1'b1;
        status_reg[ST_TX_FREE] <= 1'b1;
      end
      if (ovr_event) begin
        status_reg[ST_OVERRUN] <= 1'b1;
      end else if (command_reg[CMD_CLEAR_OVR]) begin
        status_reg[ST_OVERRUN] <= 1'b0;
      end
      if (rx_complete) begin
        status_reg[ST_RX_FULL] <= 1'b1;
      end else if (!fifo_out_valid) begin
        status_reg[ST_RX_FULL] <= 1'b0;
      end
    end
  end

  // interrupt flags: set wins over read-clear
  logic flag_read;
  assign flag_read = rd_now && idx == IDX_IRQ_FLAG;
  always_ff @(posedge clk_i) begin
    if (rst_i || rst_req) begin
      irq_flag_reg <= BYTE_ZERO;
    end else begin
      if (flag_read) begin
        irq_flag_reg <= BYTE_ZERO;
      end
      if (rx_complete && control_reg[CTL_RX_IRQ_EN]) begin
        irq_flag_reg[IRQ_RX] <= 1'b1;
      end
      if (tx_done_i && control_reg[CTL_TX_IRQ_EN]) begin
        irq_flag_reg[IRQ_TX] <= 1'b1;
      end
      if (ovr_event && control_reg[CTL_OVR_IRQ_EN]) begin
        irq_flag_reg[IRQ_OVR] <= 1'b1;
      end
    end
  end

  // filter and timing registers, locked outside reset request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accept_code <= BYTE_ZERO;
      accept_mask <= BYTE_ONES;
      bit_timing_zero <= BYTE_ZERO;
    end else if (wr_lo && rst_req && cfg_idx) begin
      if (idx == IDX_ACCEPT_CODE) begin
        accept_code <= dat_i[7:0];
      end
      if (idx == IDX_ACCEPT_MASK) begin
        accept_mask <= dat_i[7:0];
      end
      if (idx == IDX_BIT_TIMING_ZERO) begin
        bit_timing_zero <= dat_i[7:0];
      end
    end
  end

  // read mux; locked registers read as zero
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = BYTE_ZERO;
    case (idx)
      IDX_CONTROL: rd_byte = control_reg;
      IDX_COMMAND: rd_byte = command_reg;
      IDX_STATUS: rd_byte = status_reg;
      IDX_IRQ_FLAG: rd_byte = irq_flag_reg;
      IDX_ACCEPT_CODE: rd_byte = rst_req ? accept_code : BYTE_ZERO;
      IDX_ACCEPT_MASK: rd_byte = rst_req ? accept_mask : BYTE_ZERO;
      IDX_BIT_TIMING_ZERO: rd_byte = rst_req ? bit_timing_zero : BYTE_ZERO;
      IDX_RX_DATA: rd_byte = fifo_out;
      default: rd_byte = BYTE_ZERO;
    endcase
  end

  // bus answer: one wait-free cycle, err on unmapped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= req && mapped;
      err_o <= req && !mapped;
      dat_o <= {24'h000000, rd_byte};
    end
  end

  // prescaler: tick every 2*(prescale+1) clocks, reload on change
  logic [5:0] prescale_seen;
  logic [PRESCALE_W-1:0] pre_count;
  logic [PRESCALE_W-1:0] pre_reload;
  assign pre_reload = PRESCALE_W'({bit_timing_zero[BT_PRESCALE_MSB:0], 1'b0} + 7'h01);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prescale_seen <= 6'h00;
      pre_count <= '0;
      scl_tick_o <= 1'b0;
    end else begin
      prescale_seen <= bit_timing_zero[BT_PRESCALE_MSB:0];
      scl_tick_o <= 1'b0;
      if (prescale_seen != bit_timing_zero[BT_PRESCALE_MSB:0]) begin
        pre_count <= pre_reload;
      end else if (pre_count == '0) begin
        pre_count <= pre_reload;
        scl_tick_o <= 1'b1;
      end else begin
        pre_count <= pre_count - 1'b1;
      end
    end
  end

  // resync: phase error clamped to jump width plus one
  logic [3:0] jump_limit;
  assign jump_limit = {2'b00, bit_timing_zero[7:BT_JUMP_LSB]} + 4'h1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resync_o <= 1'b0;
      resync_step_o <= 3'h0;
    end else begin
      resync_o <= bus_edge_i && !rst_req;
      resync_step_o <= 3'((phase_err_i > jump_limit) ? jump_limit : phase_err_i);
    end
  end

  // registered copies for status pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_request_o <= 1'b1;
      irq_o <= 1'b0;
    end else begin
      reset_request_o <= rst_req || bus_off_i;
      irq_o <= |irq_flag_reg;
    end
  end
endmodule
`default_nettype wire

// ===== bench/canraf_partner.sv
// partner model: frame engine feeding message events
`timescale 1ns/1ps
`default_nettype none
module canraf_partner (
  // clock
  input wire logic clk_i,
  // message stream toward the block
  output logic [10:0] msg_id_o,
  output logic msg_start_o,
  output logic msg_own_o,
  output logic [7:0] msg_byte_o,
  output logic msg_valid_o,
  output logic msg_done_o
);
  // idle: strobes low, payload lines hold junk
  initial begin
    msg_id_o = 11'h7ff;
    msg_start_o = 1'b0;
    msg_own_o = 1'b0;
    msg_byte_o = 8'h5a;
    msg_valid_o = 1'b0;
    msg_done_o = 1'b0;
  end
  // one whole message; gap idles between bytes to act slowly
  task automatic send(input logic [10:0] id, input logic own, input int n, input logic [7:0] base,
                      input int gap);
    @(posedge clk_i);
    msg_start_o <= 1'b1;
    msg_id_o <= id;
    msg_own_o <= own;
    @(posedge clk_i);
    msg_start_o <= 1'b0;
    msg_id_o <= ~id;  // id is only meaningful with start
    // descriptor then data, in order
    for (int i = 0; i < n; i++) begin
      msg_byte_o <= base + 8'(i);
      msg_valid_o <= 1'b1;
      @(posedge clk_i);
      if (gap > 0) begin
        msg_valid_o <= 1'b0;
        repeat (gap) @(posedge clk_i);
      end
    end
    if (gap == 0) msg_valid_o <= 1'b0;
    msg_done_o <= 1'b1;
    @(posedge clk_i);
    msg_done_o <= 1'b0;
    msg_byte_o <= ~msg_byte_o;  // released line shows junk
    repeat (2) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== bench/canraf_assertions.sv
// checker: bus answers, reset state, bus-off hold, resync limits
`timescale 1ns/1ps
`default_nettype none
module canraf_assertions (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [5:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  // engine side
  input wire logic msg_done_i,
  input wire logic bus_off_i,
  input wire logic bus_edge_i,
  input wire logic [3:0] phase_err_i,
  // outputs
  input wire logic scl_tick_o,
  input wire logic [2:0] resync_step_o,
  input wire logic resync_o,
  input wire logic reset_request_o,
  input wire logic irq_o
);
  // one domain, so clock and reset given once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // mapped request answered by ack next cycle
  a_bus_answer: assert property (cyc_i && stb_i && !ack_o && !err_o && !adr_i[5] && adr_i[1:0] == 2'b00
    |=> ack_o && !err_o) else $error("mapped access not acked");
  // unmapped request answered by err
  a_bus_unmapped: assert property (cyc_i && stb_i && !ack_o && !err_o && (adr_i[5] || adr_i[1:0] != 2'b00)
    |=> err_o && !ack_o) else $error("unmapped access not refused");
  // byte registers: upper lanes zero, ack one cycle
  a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0 ##1 !ack_o)
    else $error("read data or ack shape wrong");
  // reset leaves reset request set, no irq
  a_reset_state: assert property ($fell(rst_i) |-> reset_request_o && !irq_o && !ack_o)
    else $error("reset state wrong");
  // bus off drives reset request
  a_busoff_holds: assert property (bus_off_i |=> reset_request_o)
    else $error("bus off without reset request");
  // resync only from an edge, never beyond the phase error
  a_resync_cause: assert property (resync_o |-> $past(bus_edge_i) && {1'b0, resync_step_o} <= $past(phase_err_i))
    else $error("resync without cause");
  // step capped at four; small errors taken whole
  a_jump_bound: assert property (resync_o |-> resync_step_o <= 3'h4 &&
    ($past(phase_err_i) > 4'h1 || {1'b0, resync_step_o} == $past(phase_err_i))) else $error("resync step wrong");
  // tick period is at least two clocks
  a_tick_pulse: assert property (scl_tick_o |=> !scl_tick_o)
    else $error("tick too close");
  // main scenarios
  c_rx_irq: cover property (msg_done_i ##[1:4] irq_o);
  c_resync: cover property (resync_o);
  c_busoff: cover property (bus_off_i ##1 reset_request_o);
endmodule
bind canraf_top canraf_assertions canraf_assertions_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .msg_done_i(msg_done_i),
  .bus_off_i(bus_off_i), .bus_edge_i(bus_edge_i), .phase_err_i(phase_err_i), .scl_tick_o(scl_tick_o),
  .resync_step_o(resync_step_o), .resync_o(resync_o), .reset_request_o(reset_request_o), .irq_o(irq_o));
`default_nettype wire

// ===== bench/testbench.sv
// testbench: registers, filter, receive store and timing
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  import canraf_pkg::*;
  // byte addresses
  localparam logic [5:0] A_CT = 6'h00, A_CM = 6'h04, A_ST = 6'h08, A_IR = 6'h0c;
  localparam logic [5:0] A_CD = 6'h10, A_MK = 6'h14, A_BT = 6'h18, A_RX = 6'h1c;
  // clock, reset, bus
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ef;
  logic [5:0] adr = 6'h00;
  logic [31:0] dat = 32'h0, dat_o, q;
  logic ack_o, err_o, tick, rsy, rr, irq, mst, mown, mval, mdone;
  // engine side
  logic bedge = 1'b0, boff = 1'b0;
  logic [3:0] phase = 4'h0;
  logic [2:0] step;
  logic [10:0] mid;
  logic [7:0] mbyte;
  int bad_count = 0, n_compared = 0;
  // 40 MHz
  always #12.5 clk_i = ~clk_i;
  canraf_top canraf_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'h1), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .msg_id_i(mid), .msg_start_i(mst), .msg_own_tx_i(mown), .msg_byte_i(mbyte),
    .msg_byte_valid_i(mval), .msg_done_i(mdone), .tx_done_i(1'b0), .bus_off_i(boff),
    .bus_edge_i(bedge), .phase_err_i(phase), .scl_tick_o(tick), .resync_step_o(step),
    .resync_o(rsy), .reset_request_o(rr), .irq_o(irq));
  canraf_partner canraf_partner_inst (.clk_i(clk_i), .msg_id_o(mid), .msg_start_o(mst),
    .msg_own_o(mown), .msg_byte_o(mbyte), .msg_valid_o(mval), .msg_done_o(mdone));
  // one classic cycle; held until ack or err is sampled
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    // no cycle budget here: only the watchdog ends a hung access
    do begin
      @(posedge clk_i);
    end while (!(ack_o || err_o));
    q = dat_o;
    ef = err_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // released lines show junk so stray decoding would show up
    adr <= ~a;
    dat <= ~{24'h0, d};
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    `CHK(q[7:0], e)
  endtask
  // skip two ticks, then time one full period
  task automatic period(input int e);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (tick !== 1'b1 && n < 300);
    end
    `CHK(n, e)
  endtask
  // one bus edge with a given phase error
  task automatic resync(input logic [3:0] p, input logic [2:0] e);
    @(posedge clk_i);
    bedge <= 1'b1;
    phase <= p;
    @(posedge clk_i);
    bedge <= 1'b0;
    @(posedge clk_i);
    `CHK(rsy, 1'b1)
    `CHK(step, e)
  endtask
  // reset values, unmapped access, config lock
  task automatic t_regs;
    rd(A_CT, 8'h21);
    rd(A_ST, 8'h0c);
    rd(A_MK, 8'hff);
    rd(A_CM, 8'hcc);
    wb(1'b0, 6'h21, 8'h00);
    `CHK(ef, 1'b1)
    wr(A_CT, 8'h00);
    wr(A_CD, 8'h55);
    rd(A_CD, 8'h00);
    wr(A_CT, 8'h01);
    rd(A_CD, 8'h00);
    rd(A_CT, 8'h01);
    wr(A_CD, 8'ha5);
    rd(A_CD, 8'ha5);
    wr(A_MK, 8'h0f);
    rd(A_MK, 8'h0f);
  endtask
  // prescaler period, reload, jump limit
  task automatic t_timing;
    wr(A_BT, 8'hc3);
    rd(A_BT, 8'hc3);
    period(8);
    wr(A_BT, 8'h00);
    period(2);
    wr(A_BT, 8'hc3);
    wr(A_CT, 8'h00);
    resync(4'h7, 3'h4);
    resync(4'h2, 3'h2);
  endtask
  // accept, flag, read-clear, reject on relevant bits
  task automatic t_filter;
    wr(A_CT, 8'h02);
    canraf_partner_inst.send({8'ha3, 3'h5}, 1'b0, 2, 8'h10, 0);
    wb(1'b0, A_ST, 8'h00);
    `CHK(q[0], 1'b1)
    `CHK(irq, 1'b1)
    rd(A_IR, 8'h01);
    rd(A_IR, 8'h00);
    rd(A_RX, 8'h10);
    rd(A_RX, 8'h11);
    canraf_partner_inst.send({8'h25, 3'h0}, 1'b0, 2, 8'h40, 1);
    canraf_partner_inst.send({8'hb5, 3'h0}, 1'b0, 2, 8'h50, 1);
    wb(1'b0, A_ST, 8'h00);
    `CHK(q[0], 1'b0)
    rd(A_IR, 8'h00);
  endtask
  // fill until refused, overrun, own frame, drain, flush
  task automatic t_overrun;
    for (int i = 0; i < 3; i++) canraf_partner_inst.send({8'ha5, 3'h0}, 1'b0, 10, 8'h20 + 8'(10 * i), i);
    canraf_partner_inst.send({8'ha5, 3'h0}, 1'b0, 10, 8'h80, 0);
    wb(1'b0, A_ST, 8'h00);
    `CHK(q[1:0], 2'b11)
    wr(A_CM, 8'h08);
    canraf_partner_inst.send({8'ha5, 3'h0}, 1'b1, 10, 8'h90, 0);
    wb(1'b0, A_ST, 8'h00);
    `CHK(q[1], 1'b1)
    for (int i = 0; i < 30; i++) rd(A_RX, 8'h20 + 8'(i));
    wb(1'b0, A_ST, 8'h00);
    `CHK(q[0], 1'b0)
    wr(A_CT, 8'h01);
    rd(A_ST, 8'h0c);
    rd(A_IR, 8'h00);
    rd(A_CM, 8'h0c);
    wr(A_CT, 8'h02);
    canraf_partner_inst.send({8'ha5, 3'h0}, 1'b1, 2, 8'h60, 0);
    wb(1'b0, A_ST, 8'h00);
    `CHK(q[0], 1'b0)
    rd(A_IR, 8'h00);
    rd(A_RX, 8'h60);
    wr(A_CT, 8'h01);
  endtask
  // bus off holds reset request until cleared
  task automatic t_busoff;
    wr(A_CT, 8'h00);
    boff <= 1'b1;
    repeat (3) @(posedge clk_i);
    boff <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK(rr, 1'b1)
    rd(A_CT, 8'h01);
    wr(A_CT, 8'h00);
    repeat (3) @(posedge clk_i);
    `CHK(rr, 1'b0)
  endtask
  // verdict and end of run
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // hang guard, well past the expected run
  initial begin
    #(25 * 40000);
    bad_count++;
    stop_test;
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_timing;
    t_filter;
    t_overrun;
    t_busoff;
    stop_test;
  end
endmodule
`default_nettype wire
